// ### fblp_core.sv
/*
 Flash boot lock protection: decides per access whether a self-program store or
 program-memory load may proceed, gates interrupts, and picks the reset vector.
 Assumes the core presents one request at a time on clk_sys and that fuses and
 the programming interface are synchronous to clk_sys.
*/
`timescale 1ns/100ps
module fblp_core
    import fblp_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    // Fuses, driven only by the programming interface
    input  wire logic              boot_reset_select_fuse,
    input  wire logic [1:0]        boot_size_fuses,
    // Core state
    input  wire logic [ADDR_W-1:0] exec_addr,
    input  wire logic              vectors_in_boot,
    input  wire logic              irq_req,
    // Core access request
    input  wire logic              store_req,
    input  wire logic              load_req,
    input  wire logic [ADDR_W-1:0] access_addr,
    // Lock programming
    input  wire logic              lock_write_sw,
    input  wire logic              lock_write_prog,
    input  wire logic [7:0]        lock_data,
    input  wire logic              chip_erase,
    // Decisions
    output logic                   store_grant,
    output logic                   load_grant,
    output logic                   access_done,
    output logic                   irq_gated,
    output logic [ADDR_W-1:0]      reset_vector,
    output logic [ADDR_W-1:0]      boot_start,
    output logic [1:0]             app_section_lock_field,
    output logic [1:0]             boot_section_lock_field
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [1:0]        app_lock;
        logic [1:0]        boot_lock;
        logic              store_grant;
        logic              load_grant;
        logic              done;
    } fblp_state_t;

    fblp_state_t st;
    fblp_state_t next_st;

    function automatic logic [ADDR_W-1:0] boot_size(input logic [1:0] f);
        unique case (f)
            2'h0: boot_size = BOOT_WORDS_00;
            2'h1: boot_size = BOOT_WORDS_01;
            2'h2: boot_size = BOOT_WORDS_10;
            2'h3: boot_size = BOOT_WORDS_11;
        endcase
    endfunction

    logic [ADDR_W-1:0] bstart;
    logic              exec_in_boot;
    logic              tgt_in_boot;
    logic              wr_ok_app;
    logic              wr_ok_boot;
    logic              rd_ok_app;
    logic              rd_ok_boot;

    // ==========================================================
    // Section decode and lock decisions
    always_comb
    begin
        bstart       = ADDR_W'(FLASH_TOP - boot_size(boot_size_fuses) + 14'h0001); // [R20]
        exec_in_boot = exec_addr >= bstart;
        tgt_in_boot  = access_addr >= bstart;
        // Lower bit 1 means writes allowed; modes 1 and 4 [R2] [R3] [R4] [R5] [R6]
        wr_ok_app    = (st.app_lock == 2'h3) || (st.app_lock == 2'h1);
        wr_ok_boot   = (st.boot_lock == 2'h3) || (st.boot_lock == 2'h1); // [R8] [R9] [R10] [R11]
        // Cross-section loads blocked once the target field's upper bit is programmed
        rd_ok_app    = st.app_lock[1] | ~exec_in_boot;  // [R5] [R6]
        rd_ok_boot   = st.boot_lock[1] | exec_in_boot;  // [R10] [R11]
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        next_st = st;
        next_st.done = store_req | load_req;
        // Stores only from boot code; general lock bits play no part [R19] [R14] [R15]
        next_st.store_grant = store_req & exec_in_boot & (tgt_in_boot ? wr_ok_boot : wr_ok_app);
        next_st.load_grant  = load_req & (tgt_in_boot ? rd_ok_boot : rd_ok_app);
        // Programming only clears bits; a write cannot unprogram [R13]
        if (lock_write_prog || (lock_write_sw && exec_in_boot))
        begin
            next_st.app_lock  = st.app_lock  & lock_data[LB_APP_HI:LB_APP_LO];   // [R1]
            next_st.boot_lock = st.boot_lock & lock_data[LB_BOOT_HI:LB_BOOT_LO]; // [R1]
        end
        if (chip_erase)
        begin
            next_st.app_lock  = LOCK_ERASED; // [R13]
            next_st.boot_lock = LOCK_ERASED;
        end
    end

    // Lock state lives in nonvolatile cells; reset shows the erased pattern here
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            st <= '{app_lock: LOCK_ERASED, boot_lock: LOCK_ERASED, default: 1'b0};
        else
            st <= next_st;
    end

    // ==========================================================
    // Outputs
    // A refused access simply completes without a grant: no fault line exists [R21]
    assign store_grant             = st.store_grant;
    assign load_grant              = st.load_grant;
    assign access_done             = st.done;
    assign irq_gated               = irq_req
        & ~(vectors_in_boot & ~exec_in_boot & ~st.app_lock[1])   // [R7]
        & ~(~vectors_in_boot & exec_in_boot & ~st.boot_lock[1]); // [R12]
    // Fuses are inputs only; nothing here can write them [R18]
    assign reset_vector            = boot_reset_select_fuse ? APP_RESET_ADR : bstart; // [R16] [R17]
    assign boot_start              = bstart;
    assign app_section_lock_field  = st.app_lock;
    assign boot_section_lock_field = st.boot_lock;

    // ==========================================================
    // Checks
    property p_store_app_block;
        @(posedge clk_sys) disable iff (!rst_n)
        (store_req && !(access_addr >= bstart) && !st.app_lock[0] && st.app_lock[1]) |=> !store_grant;
    endproperty
    a_store_app_block: assert property (p_store_app_block) else $error("store to locked app section"); // [R4]

    property p_store_from_app;
        @(posedge clk_sys) disable iff (!rst_n)
        (store_req && !(exec_addr >= bstart)) |=> !store_grant;
    endproperty
    a_store_from_app: assert property (p_store_from_app) else $error("store granted from app code"); // [R19]

    property p_load_boot_block;
        @(posedge clk_sys) disable iff (!rst_n)
        (load_req && exec_addr < bstart && access_addr >= bstart && !st.boot_lock[1]) |=> !load_grant;
    endproperty
    a_load_boot_block: assert property (p_load_boot_block) else $error("load of locked boot section"); // [R10]

    property p_open_store;
        @(posedge clk_sys) disable iff (!rst_n)
        (store_req && exec_addr >= bstart && access_addr >= bstart && st.boot_lock == 2'h3
            && !lock_write_prog) |=> store_grant;
    endproperty
    a_open_store: assert property (p_open_store) else $error("open boot store refused"); // [R8]

    property p_lock_sticky;
        @(posedge clk_sys) disable iff (!rst_n)
        (!chip_erase) |=> ((app_section_lock_field & ~$past(app_section_lock_field)) == 2'h0);
    endproperty
    a_lock_sticky: assert property (p_lock_sticky) else $error("lock bit unprogrammed"); // [R13]

    property p_reset_vec;
        @(posedge clk_sys) disable iff (!rst_n)
        boot_reset_select_fuse |-> reset_vector == APP_RESET_ADR;
    endproperty
    a_reset_vec: assert property (p_reset_vec) else $error("wrong reset vector"); // [R16]

    property p_irq_gate;
        @(posedge clk_sys) disable iff (!rst_n)
        (vectors_in_boot && exec_addr < bstart && !app_section_lock_field[1]) |-> !irq_gated;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq not suppressed"); // [R7]

    property p_done;
        @(posedge clk_sys) disable iff (!rst_n)
        (load_req || store_req) |=> access_done;
    endproperty
    a_done: assert property (p_done) else $error("access not completed"); // [R21]

    // ==========================================================
    // Per-mode checks built from the access sequences, then load, irq, vector, boundary, lock and handshake checks
    sequence s_store_from_boot;
        store_req && exec_addr >= bstart;
    endsequence

    sequence s_load_cross_app;
        load_req && exec_addr >= bstart && access_addr < bstart;
    endsequence

    sequence s_load_cross_boot;
        load_req && exec_addr < bstart && access_addr >= bstart;
    endsequence

    sequence s_refused_store;
        access_done && !store_grant;
    endsequence

    sequence s_refused_load;
        access_done && !load_grant;
    endsequence

    property p_store_app_mode3;
        @(posedge clk_sys) disable iff (!rst_n)
        s_store_from_boot ##0 (access_addr < bstart && st.app_lock == 2'h0) |=> s_refused_store;
    endproperty
    a_store_app_mode3: assert property (p_store_app_mode3) else $error("store to app in mode 3"); // [R5]

    property p_store_boot_mode2;
        @(posedge clk_sys) disable iff (!rst_n)
        s_store_from_boot ##0 (access_addr >= bstart && st.boot_lock == 2'h2) |=> s_refused_store;
    endproperty
    a_store_boot_mode2: assert property (p_store_boot_mode2) else $error("store to boot in mode 2"); // [R9]

    property p_store_boot_mode3;
        @(posedge clk_sys) disable iff (!rst_n)
        s_store_from_boot ##0 (access_addr >= bstart && st.boot_lock == 2'h0) |=> s_refused_store;
    endproperty
    a_store_boot_mode3: assert property (p_store_boot_mode3) else $error("store to boot in mode 3"); // [R10]

    property p_store_app_open;
        @(posedge clk_sys) disable iff (!rst_n)
        s_store_from_boot ##0 (access_addr < bstart && st.app_lock[0]) |=> store_grant;
    endproperty
    a_store_app_open: assert property (p_store_app_open) else $error("open app store refused"); // [R3] [R6]

    property p_store_boot_mode4;
        @(posedge clk_sys) disable iff (!rst_n)
        s_store_from_boot ##0 (access_addr >= bstart && st.boot_lock == 2'h1) |=> store_grant;
    endproperty
    a_store_boot_mode4: assert property (p_store_boot_mode4) else $error("boot store refused in mode 4"); // [R11]

    property p_load_app_block;
        @(posedge clk_sys) disable iff (!rst_n)
        s_load_cross_app ##0 (!st.app_lock[1]) |=> s_refused_load;
    endproperty
    a_load_app_block: assert property (p_load_app_block) else $error("load of locked app section"); // [R5] [R6]

    property p_load_app_open;
        @(posedge clk_sys) disable iff (!rst_n)
        s_load_cross_app ##0 st.app_lock[1] |=> load_grant;
    endproperty
    a_load_app_open: assert property (p_load_app_open) else $error("open app load refused"); // [R3] [R4]

    property p_load_boot_open;
        @(posedge clk_sys) disable iff (!rst_n)
        s_load_cross_boot ##0 st.boot_lock[1] |=> load_grant;
    endproperty
    a_load_boot_open: assert property (p_load_boot_open) else $error("open boot load refused"); // [R8] [R9]

    property p_load_boot_mode4;
        @(posedge clk_sys) disable iff (!rst_n)
        s_load_cross_boot ##0 (st.boot_lock == 2'h1) |=> s_refused_load;
    endproperty
    a_load_boot_mode4: assert property (p_load_boot_mode4) else $error("boot load granted in mode 4"); // [R11]

    property p_load_same;
        @(posedge clk_sys) disable iff (!rst_n)
        (load_req && ((exec_addr >= bstart) == (access_addr >= bstart))) |=> load_grant;
    endproperty
    a_load_same: assert property (p_load_same) else $error("same section load refused"); // [R15]

    property p_irq_gate_boot;
        @(posedge clk_sys) disable iff (!rst_n)
        (!vectors_in_boot && exec_addr >= bstart && !boot_section_lock_field[1]) |-> !irq_gated;
    endproperty
    a_irq_gate_boot: assert property (p_irq_gate_boot) else $error("irq not suppressed in boot"); // [R12]

    property p_irq_pass;
        @(posedge clk_sys) disable iff (!rst_n)
        (irq_req && app_section_lock_field[1] && boot_section_lock_field[1]) |-> irq_gated;
    endproperty
    a_irq_pass: assert property (p_irq_pass) else $error("irq suppressed without lock"); // [R7] [R12]

    property p_irq_idle;
        @(posedge clk_sys) disable iff (!rst_n)
        !irq_req |-> !irq_gated;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("irq out without request"); // [R7]

    property p_boot_vec;
        @(posedge clk_sys) disable iff (!rst_n)
        !boot_reset_select_fuse |-> reset_vector == boot_start;
    endproperty
    a_boot_vec: assert property (p_boot_vec) else $error("boot reset vector wrong"); // [R17]

    property p_boundary;
        @(posedge clk_sys) disable iff (!rst_n)
        ADDR_W'(boot_start + boot_size(boot_size_fuses)) == '0;
    endproperty
    a_boundary: assert property (p_boundary) else $error("boot section not at flash top"); // [R20]

    property p_boot_sticky;
        @(posedge clk_sys) disable iff (!rst_n)
        (!chip_erase) |=> ((boot_section_lock_field & ~$past(boot_section_lock_field)) == 2'h0);
    endproperty
    a_boot_sticky: assert property (p_boot_sticky) else $error("boot lock bit unprogrammed"); // [R13]

    property p_erase;
        @(posedge clk_sys) disable iff (!rst_n)
        chip_erase |=> (app_section_lock_field == LOCK_ERASED && boot_section_lock_field == LOCK_ERASED);
    endproperty
    a_erase: assert property (p_erase) else $error("erase did not clear locks"); // [R13]

    property p_sw_from_app;
        @(posedge clk_sys) disable iff (!rst_n)
        (lock_write_sw && !lock_write_prog && !chip_erase && exec_addr < bstart)
            |=> ($stable(app_section_lock_field) && $stable(boot_section_lock_field));
    endproperty
    a_sw_from_app: assert property (p_sw_from_app) else $error("lock written from app code"); // [R19]

    property p_boot_field_kept;
        @(posedge clk_sys) disable iff (!rst_n)
        (lock_write_prog && !chip_erase && lock_data[LB_BOOT_HI:LB_BOOT_LO] == 2'h3) |=> $stable(boot_section_lock_field);
    endproperty
    a_boot_field_kept: assert property (p_boot_field_kept) else $error("boot field disturbed"); // [R1]

    property p_grant_done;
        @(posedge clk_sys) disable iff (!rst_n)
        (store_grant || load_grant) |-> access_done;
    endproperty
    a_grant_done: assert property (p_grant_done) else $error("grant without done"); // [R21]

    property p_idle_quiet;
        @(posedge clk_sys) disable iff (!rst_n)
        (!store_req && !load_req) |=> (!store_grant && !load_grant && !access_done);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("answer without request"); // [R21]

endmodule // fblp_core

// ### fblp_core_model.sv
/*
 Core model: issues self-program stores and program-memory loads.
 Assumes one clk_sys domain and an answer one cycle after each request.
*/
`timescale 1ns/100ps
module fblp_core_model
    import fblp_pkg::*;
(
    // Clock and answers
    input  wire logic         clk_sys,
    input  wire logic         access_done,
    input  wire logic         store_grant,
    input  wire logic         load_grant,
    // Core state and requests
    output logic [ADDR_W-1:0] exec_addr,
    output logic              vectors_in_boot,
    output logic              irq_req,
    output logic              store_req,
    output logic              load_req,
    output logic [ADDR_W-1:0] access_addr
);
    initial
    begin
        {exec_addr, vectors_in_boot, irq_req, store_req, load_req, access_addr} = '0;
    end
    // k = {store, back to back, vectors in boot, irq}; a second request is the other kind
    task automatic access(input logic [3:0] k, input logic [13:0] ex, ad, output logic [3:0] seen);
        @(posedge clk_sys);
        #1;
        {exec_addr, access_addr, vectors_in_boot, irq_req, store_req, load_req} = {ex, ad, k[1:0], k[3], !k[3]};
        @(posedge clk_sys);
        #1;
        seen[3:2] = {access_done, k[3] ? store_grant : load_grant};
        {store_req, load_req} = {!k[3] & k[2], k[3] & k[2]};
        @(posedge clk_sys);
        #1;
        seen[1:0] = {access_done, k[3] ? load_grant : store_grant};
        store_req = 1'h0;
        load_req = 1'h0;
        // Released bus shows the inverse, so a stale address cannot match
        access_addr = ~ad;
    endtask
endmodule // fblp_core_model

// ### fblp_pkg.sv
/*
 Constants for the flash boot lock protection block.
 Assumes a 10 MHz system clock and a 14-bit word address into program flash.
*/
// Notes on behaviour
// R1: Two independent lock fields guard the application and boot sections separately.
// R2: In every lock bit and fuse, 1 means unprogrammed and 0 programmed.
// R3: Application mode 1 (11) allows all writes and reads of the application section.
// R4: Application mode 2 (10) blocks self-program writes to the application section.
// R5: Application mode 3 (00) blocks writes and boot-code reads of the application section.
// R6: Application mode 4 (01) allows writes but blocks boot-code reads of application section.
// R7: Application modes 3/4 with vectors in boot: interrupts off while running application.
// R8: Boot mode 1 (11) allows all writes and reads of the boot section.
// R9: Boot mode 2 (10) blocks self-program writes to the boot section.
// R10: Boot mode 3 (00) blocks writes and application-code reads of the boot section.
// R11: Boot mode 4 (01) allows writes but blocks application-code reads of boot section.
// R12: Boot modes 3/4 with vectors in application: interrupts off while running boot.
// R13: Lock bits are programmed by software or programmer; only chip erase clears them. Here reset also reloads the erased pattern.
// R14: General write lock does not affect self-program writes to flash.
// R15: General read/write lock does not restrict software loads or stores.
// R16: Boot reset fuse unprogrammed: reset starts at the application reset address.
// R17: Boot reset fuse programmed: reset starts at the boot section start address.
// R18: Running code cannot alter fuses; only the programming interface changes them.
// R19: Self-program stores executed from the application section are disabled.
// R20: Boot size fuses set the section boundary and the boot start address.
// R21: A blocked access leaves flash unchanged and raises no fault.
package fblp_pkg;
    localparam int          ADDR_W        = 14;
    localparam logic [13:0] APP_RESET_ADR = 14'h0000;
    // Boot section sizes in words, indexed by the two boot size fuses
    localparam logic [13:0] BOOT_WORDS_00 = 14'h1000;
    localparam logic [13:0] BOOT_WORDS_01 = 14'h0800;
    localparam logic [13:0] BOOT_WORDS_10 = 14'h0400;
    localparam logic [13:0] BOOT_WORDS_11 = 14'h0200;
    localparam logic [13:0] FLASH_TOP     = 14'h3fff;
    localparam logic [1:0]  LOCK_ERASED   = 2'h3;
    // Field positions within a lock byte
    localparam int          LB_APP_LO     = 2;
    localparam int          LB_APP_HI     = 3;
    localparam int          LB_BOOT_LO    = 4;
    localparam int          LB_BOOT_HI    = 5;
endpackage

// ### flash_boot_lock_protection_test.sv
/*
 Self-checking bench for the flash boot lock protection block.
 Assumes fblp_core, fblp_core_model and a 10 MHz clk_sys.
*/
`timescale 1ns/100ps
module flash_boot_lock_protection_test;
    import fblp_pkg::*;
    localparam logic [13:0] A = 14'h0100, B = 14'h3f00;
    logic clk_sys = 1'h0, rst_n = 1'h0, boot_reset_select_fuse = 1'h1;
    logic lock_write_sw = 1'h0, lock_write_prog = 1'h0, chip_erase = 1'h0;
    logic [1:0] boot_size_fuses = 2'h3;
    logic [7:0] lock_data = 8'hff;
    logic [13:0] exec_addr, access_addr, reset_vector, boot_start;
    logic vectors_in_boot, irq_req, store_req, load_req, store_grant, load_grant, access_done, irq_gated;
    logic [1:0] app_section_lock_field, boot_section_lock_field;
    wire [3:0] lock_view = {boot_section_lock_field, app_section_lock_field};
    wire [6:0] quiet_view = {store_grant, load_grant, access_done, lock_view};
    logic [3:0] seen;
    logic [15:0] r;
    logic [13:0] sizes [4] = '{BOOT_WORDS_00, BOOT_WORDS_01, BOOT_WORDS_10, BOOT_WORDS_11};
    int n_errors = 0, check_count = 0, cyc = 0;
    // {lock byte, exec in boot, target in boot, store, vectors in boot, grant, irq out}
    logic [15:0] rows [19] = '{16'hff2b, 16'hfb29, 16'hf329, 16'hf72b,
        16'hef39, 16'hcf38, 16'hdf3a, 16'hff3b, 16'hff0d,
        16'hf325, 16'hf725, 16'hfb27, 16'hcf11, 16'hdf11,
        16'hef13, 16'hf306, 16'hf706, 16'hfc2b, 16'hf003};
    fblp_core uut (.clk_sys, .rst_n, .boot_reset_select_fuse, .boot_size_fuses, .exec_addr, .vectors_in_boot,
        .irq_req, .store_req, .load_req, .access_addr, .lock_write_sw, .lock_write_prog, .lock_data, .chip_erase,
        .store_grant, .load_grant, .access_done, .irq_gated, .reset_vector, .boot_start,
        .app_section_lock_field, .boot_section_lock_field);
    fblp_core_model core (.clk_sys, .access_done, .store_grant, .load_grant, .exec_addr, .vectors_in_boot,
        .irq_req, .store_req, .load_req, .access_addr);
    // ========================================
    // Clock, timeout and reporting
    initial
    begin
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            n_errors++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [15:0] exp, got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // which = {erase, programmer write, software write}
    task automatic pulse(input logic [2:0] which, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        {chip_erase, lock_write_prog, lock_write_sw, lock_data} = {which, d};
        @(posedge clk_sys);
        #1;
        {chip_erase, lock_write_prog, lock_write_sw, lock_data} = {3'h0, ~d};
    endtask
    // ========================================
    // Table, then awkward cases
    initial
    begin
        repeat (5) @(posedge clk_sys);
        #1;
        rst_n = 1'h1;
        chk("idle", 8'h0f, quiet_view);
        for (int s = 0; s < 4; s++)
        begin
            {boot_size_fuses, boot_reset_select_fuse} = {2'(s), 1'h0};
            @(posedge clk_sys);
            #1;
            chk("boot_start", 14'(14'h0 - sizes[s]), boot_start);
            chk("vector_boot", 14'(14'h0 - sizes[s]), reset_vector);
            boot_reset_select_fuse = 1'h1;
            @(posedge clk_sys);
            #1;
            chk("vector_app", APP_RESET_ADR, reset_vector);
        end
        for (int i = 0; i < 19; i++)
        begin
            r = rows[i];
            pulse(3'h4, 8'hff);
            pulse(3'h2, r[15:8]);
            core.access({r[3], 1'h0, r[2], 1'h1}, r[5] ? B : A, r[4] ? B : A, seen);
            chk("fields", r[13:10], lock_view);
            chk("access", {1'h1, r[1], 2'h0}, seen);
            chk("irq_gated", r[0], irq_gated);
        end
        pulse(3'h4, 8'hff);
        pulse(3'h2, 8'hfb);
        core.access(4'hc, B, A, seen);
        chk("back_to_back", 4'hb, seen);
        core.access(4'h0, A, A, seen);
        chk("app_load", 4'hc, seen);
        pulse(3'h1, 8'hf3);
        chk("sw_from_app", 4'he, lock_view);
        core.access(4'h8, B, A, seen);
        chk("boot_store", 4'h8, seen);
        pulse(3'h1, 8'hf3);
        chk("sw_from_boot", 4'hc, lock_view);
        pulse(3'h2, 8'hff);
        chk("no_unprogram", 4'hc, lock_view);
        pulse(3'h6, 8'h00);
        chk("erase_wins", 4'hf, lock_view);
        pulse(3'h2, 8'h00);
        rst_n = 1'h0;
        @(posedge clk_sys);
        #1;
        chk("mid_reset", 8'h0f, quiet_view);
        rst_n = 1'h1;
        core.access(4'h8, B, B, seen);
        chk("after_reset", 4'hc, seen);
        final_report();
    end
endmodule // flash_boot_lock_protection_test
